// File: hw/video_out_pkg.sv
// constants shared by the video digitizer output port
package video_out_pkg;
	localparam int PIX_W = 8;
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_W = 3 * PIX_W + 2;
	localparam int FIFO_LINE_BIT = 3 * PIX_W;
	localparam int FIFO_FRAME_BIT = 3 * PIX_W + 1;
	localparam logic [6:0] ADDR_STRAP_LOW = 7'h4C;
	localparam logic [6:0] ADDR_STRAP_HIGH = 7'h4D;
	localparam logic [1:0] SEL_HSYNC = 2'h0;
	localparam logic [1:0] SEL_SOG = 2'h1;
	localparam logic [1:0] SEL_CSYNC = 2'h2;
	localparam logic [3:0] FRAME_DELAY = 4'h8;
	localparam logic [7:0] PULSE_LIMIT = 8'h40;
	localparam logic [7:0] PULSE_MAX = 8'hFF;
	localparam logic [3:0] I2C_BITS = 4'h8;
	localparam int CLK_SYNC_W = 4;
	localparam logic [CLK_SYNC_W-1:0] CLK_SYNC_RST = 4'h7;
	localparam int PX_SYNC_W = 9;
	localparam logic [PX_SYNC_W-1:0] PX_SYNC_RST = 9'h000;
endpackage : video_out_pkg

// File: hw/stream_fifo.sv
// single-clock fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	output logic [WIDTH-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_C = DEPTH[AW:0];

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic do_wr;
	logic do_rd;

	assign wr_ready_out = (count != DEPTH_C);
	assign rd_valid_out = (count != '0);
	assign do_wr = wr_valid_in && wr_ready_out;
	assign do_rd = rd_valid_out && rd_ready_in;
	assign rd_data_out = mem[rd_ptr];

	always_ff @(posedge clk_in) begin
		if (do_wr) begin
			mem[wr_ptr] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
			end
			if (do_rd) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
			end
			if (do_wr && !do_rd) begin
				count <= count + (AW+1)'(1);
			end else if (do_rd && !do_wr) begin
				count <= count - (AW+1)'(1);
			end
		end
	end
endmodule : stream_fifo
`default_nettype wire

// File: hw/video_digitizer_output_port.sv
// output port of a triple video digitizer: pixel buses, sync outputs, strap and serial slave
`timescale 1ns/1ps
`default_nettype none
module video_digitizer_output_port (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic pixel_clk_in,
	input wire logic reset_n_in,
	input wire logic bus_addr_strap_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	output logic [6:0] slave_addr_out,
	input wire logic crystal_half_in,
	output logic crystal_clock_buffered_out,
	input wire logic hsync_in,
	input wire logic sog_in,
	input wire logic csync_in,
	input wire logic vsync_in,
	input wire logic [1:0] sync_select_in,
	input wire logic mode_wide_in,
	input wire logic bus_enable_in,
	input wire logic sample_phase_invert_in,
	output logic sample_clock_out,
	input wire logic [video_out_pkg::PIX_W-1:0] adc_red_in,
	input wire logic [video_out_pkg::PIX_W-1:0] adc_green_in,
	input wire logic [video_out_pkg::PIX_W-1:0] adc_blue_in,
	input wire logic adc_valid_in,
	output logic adc_ready_out,
	output logic [video_out_pkg::PIX_W-1:0] red_primary_bus_out,
	output logic [video_out_pkg::PIX_W-1:0] green_primary_bus_out,
	output logic [video_out_pkg::PIX_W-1:0] blue_primary_bus_out,
	output logic [video_out_pkg::PIX_W-1:0] red_secondary_bus_out,
	output logic [video_out_pkg::PIX_W-1:0] green_secondary_bus_out,
	output logic [video_out_pkg::PIX_W-1:0] blue_secondary_bus_out,
	output logic pixel_bus_oe_n_out,
	output logic pixel_data_clock_out,
	output logic pixel_data_clock_n_out,
	output logic aligned_line_sync_out,
	output logic synthetic_frame_sync_out,
	output logic raw_line_sync_buffered_out,
	output logic raw_frame_sync_buffered_out
);
	import video_out_pkg::*;

	// ----------------------------------------
	// system clock domain: pins, reset, crystal
	// ----------------------------------------
	typedef enum {I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_WAIT} i2c_state_e;

	logic [CLK_SYNC_W-1:0] cs1, cs2, cs3, cst;
	logic strap_st, reset_st, scl_st, sda_st;
	logic rst_int;
	logic xdiv;
	logic scl_prev, sda_prev;
	logic [7:0] shift;
	logic [3:0] bit_cnt;
	i2c_state_e state;

	always_ff @(posedge clk_in) begin
		cs1 <= {bus_addr_strap_in, reset_n_in, scl_in, sda_in};
		cs2 <= cs1;
		cs3 <= cs2;
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cst <= CLK_SYNC_RST;
		end else begin
			for (int i = 0; i < CLK_SYNC_W; i++) begin
				if (cs2[i] == cs3[i]) begin
					cst[i] <= cs3[i];
				end
			end
		end
	end

	assign {strap_st, reset_st, scl_st, sda_st} = cst;
	assign rst_int = sys_rst_in || !reset_st;

	always_ff @(posedge clk_in) begin
		if (rst_int) begin
			xdiv <= 1'b0;
		end else begin
			xdiv <= ~xdiv;
		end
	end

	assign crystal_clock_buffered_out = crystal_half_in ? xdiv : clk_in;

	always_ff @(posedge clk_in) begin
		if (rst_int) begin
			slave_addr_out <= ADDR_STRAP_LOW;
		end else begin
			slave_addr_out <= strap_st ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW;
		end
	end

	// ----------------------------------------
	// serial slave: address match and acknowledge
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_int) begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_prev <= scl_st;
			sda_prev <= sda_st;
		end
	end

	assign sda_out = 1'b0;

	always_ff @(posedge clk_in) begin
		if (rst_int) begin
			state <= I2C_IDLE;
			shift <= 8'h00;
			bit_cnt <= 4'h0;
			sda_oe_n_out <= 1'b1;
		end else if (scl_st && scl_prev && sda_prev && !sda_st) begin
			state <= I2C_ADDR;
			bit_cnt <= 4'h0;
			sda_oe_n_out <= 1'b1;
		end else if (scl_st && scl_prev && !sda_prev && sda_st) begin
			state <= I2C_IDLE;
			sda_oe_n_out <= 1'b1;
		end else begin
			case (state)
				I2C_ADDR: begin
					if (scl_st && !scl_prev && bit_cnt != I2C_BITS) begin
						shift <= {shift[6:0], sda_st};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (!scl_st && scl_prev && bit_cnt == I2C_BITS) begin
						if (shift[7:1] == slave_addr_out) begin
							state <= I2C_ACK;
							sda_oe_n_out <= 1'b0;
						end else begin
							state <= I2C_WAIT;
						end
					end
				end
				I2C_ACK: begin
					if (!scl_st && scl_prev) begin
						state <= I2C_WAIT;
						sda_oe_n_out <= 1'b1;
					end
				end
				I2C_IDLE, I2C_WAIT: begin
					sda_oe_n_out <= 1'b1;
				end
				default: begin
					state <= I2C_IDLE;
					sda_oe_n_out <= 1'b1;
				end
			endcase
		end
	end

	a_addr_strap: assert property (@(posedge clk_in) disable iff (rst_int)
		$stable(strap_st) |=> slave_addr_out == ($past(strap_st) ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW))
		else $error("slave address does not follow strap");
	a_sda_open_drain: assert property (@(posedge clk_in) disable iff (rst_int)
		!sda_oe_n_out |-> state == I2C_ACK && sda_out == 1'b0)
		else $error("data line driven outside acknowledge");
	a_crystal_half: assert property (@(posedge clk_in) disable iff (rst_int)
		!$past(rst_int) |-> xdiv != $past(xdiv))
		else $error("crystal divider not toggling");
	a_reset_tied: assert property (@(posedge clk_in)
		reset_st && !sys_rst_in |-> !rst_int)
		else $error("reset active with pin high");

	// ----------------------------------------
	// pixel clock domain: crossings and sync handling
	// ----------------------------------------
	logic rs1, rs2, rs3, px_rst;
	logic [PX_SYNC_W-1:0] ps1, ps2, ps3, pst;
	logic in_hsync, in_sog, in_csync, in_vsync, in_inv, in_wide, in_bus_en;
	logic [1:0] in_sel;
	logic sel_sync, composite, disrupt, frame_src, frame_mark, line_bit;
	logic [7:0] width;
	logic wr_frame_pend;

	always_ff @(posedge pixel_clk_in) begin
		rs1 <= rst_int;
		rs2 <= rs1;
		rs3 <= rs2;
		if (rs2 == rs3) begin
			px_rst <= rs3;
		end
	end

	always_ff @(posedge pixel_clk_in) begin
		ps1 <= {hsync_in, sog_in, csync_in, vsync_in, sample_phase_invert_in,
			mode_wide_in, bus_enable_in, sync_select_in};
		ps2 <= ps1;
		ps3 <= ps2;
	end

	always_ff @(posedge pixel_clk_in) begin
		if (px_rst) begin
			pst <= PX_SYNC_RST;
		end else begin
			for (int i = 0; i < PX_SYNC_W; i++) begin
				if (ps2[i] == ps3[i]) begin
					pst[i] <= ps3[i];
				end
			end
		end
	end

	assign {in_hsync, in_sog, in_csync, in_vsync, in_inv, in_wide, in_bus_en, in_sel} = pst;
	assign sample_clock_out = pixel_clk_in ^ in_inv;

	always_comb begin
		case (in_sel)
			SEL_HSYNC: sel_sync = in_hsync;
			SEL_SOG: sel_sync = in_sog;
			SEL_CSYNC: sel_sync = in_csync;
			default: sel_sync = in_hsync;
		endcase
	end

	assign composite = (in_sel == SEL_CSYNC);

	always_ff @(posedge pixel_clk_in) begin
		if (px_rst) begin
			raw_line_sync_buffered_out <= 1'b0;
		end else begin
			raw_line_sync_buffered_out <= sel_sync;
		end
	end

	always_ff @(posedge pixel_clk_in) begin
		if (px_rst || !sel_sync) begin
			width <= 8'h00;
		end else if (width != PULSE_MAX) begin
			width <= width + 8'h01;
		end
	end

	always_ff @(posedge pixel_clk_in) begin
		if (px_rst) begin
			disrupt <= 1'b0;
		end else if (sel_sync && width == PULSE_LIMIT) begin
			disrupt <= 1'b1;
		end else if (raw_line_sync_buffered_out && !sel_sync && width < PULSE_LIMIT) begin
			disrupt <= 1'b0;
		end
	end

	assign frame_src = composite ? disrupt : in_vsync;
	assign frame_mark = frame_src && !raw_frame_sync_buffered_out;
	assign line_bit = composite ? (sel_sync && !disrupt) : sel_sync;

	always_ff @(posedge pixel_clk_in) begin
		if (px_rst) begin
			raw_frame_sync_buffered_out <= 1'b0;
		end else begin
			raw_frame_sync_buffered_out <= frame_src;
		end
	end

	// ----------------------------------------
	// pixel fifo and output buses
	// ----------------------------------------
	logic [FIFO_W-1:0] rd_data;
	logic rd_valid, rd_ready, pop, fire, phase, half, line_prev, frame_pend;
	logic [3:0] trail_cnt;

	assign fire = adc_valid_in && adc_ready_out;

	always_ff @(posedge pixel_clk_in) begin
		if (px_rst) begin
			wr_frame_pend <= 1'b0;
		end else begin
			wr_frame_pend <= fire ? 1'b0 : (wr_frame_pend || frame_mark);
		end
	end

	stream_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_in(pixel_clk_in),
		.rst_in(px_rst),
		.wr_data_in({wr_frame_pend || frame_mark, line_bit, adc_red_in, adc_green_in, adc_blue_in}),
		.wr_valid_in(adc_valid_in),
		.wr_ready_out(adc_ready_out),
		.rd_data_out(rd_data),
		.rd_valid_out(rd_valid),
		.rd_ready_in(rd_ready)
	);

	assign rd_ready = in_bus_en && !pixel_bus_oe_n_out;
	assign pop = rd_valid && rd_ready;

	always_ff @(posedge pixel_clk_in) begin
		if (px_rst) begin
			pixel_bus_oe_n_out <= 1'b1;
		end else begin
			pixel_bus_oe_n_out <= !in_bus_en;
		end
	end

	always_ff @(posedge pixel_clk_in) begin
		if (px_rst) begin
			{red_primary_bus_out, green_primary_bus_out, blue_primary_bus_out} <= '0;
			{red_secondary_bus_out, green_secondary_bus_out, blue_secondary_bus_out} <= '0;
			aligned_line_sync_out <= 1'b0;
			phase <= 1'b0;
		end else if (pop) begin
			aligned_line_sync_out <= rd_data[FIFO_LINE_BIT];
			phase <= in_wide ? !phase : 1'b0;
			if (!in_wide || !phase) begin
				{red_primary_bus_out, green_primary_bus_out, blue_primary_bus_out} <=
					rd_data[FIFO_LINE_BIT-1:0];
			end
			if (!in_wide) begin
				{red_secondary_bus_out, green_secondary_bus_out, blue_secondary_bus_out} <= '0;
			end else if (phase) begin
				{red_secondary_bus_out, green_secondary_bus_out, blue_secondary_bus_out} <=
					rd_data[FIFO_LINE_BIT-1:0];
			end
		end
	end

	always_ff @(posedge pixel_clk_in) begin
		if (px_rst) begin
			half <= 1'b0;
		end else begin
			half <= in_wide ? !half : 1'b0;
		end
	end

	assign pixel_data_clock_out = in_wide ? half : pixel_clk_in;
	assign pixel_data_clock_n_out = !pixel_data_clock_out;

	// ----------------------------------------
	// synthetic frame sync
	// ----------------------------------------
	always_ff @(posedge pixel_clk_in) begin
		if (px_rst) begin
			line_prev <= 1'b0;
			trail_cnt <= 4'h0;
		end else begin
			line_prev <= aligned_line_sync_out;
			if (line_prev && !aligned_line_sync_out) begin
				trail_cnt <= 4'h1;
			end else if (trail_cnt == FRAME_DELAY - 4'h1) begin
				trail_cnt <= 4'h0;
			end else if (trail_cnt != 4'h0) begin
				trail_cnt <= trail_cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge pixel_clk_in) begin
		if (px_rst) begin
			frame_pend <= 1'b0;
			synthetic_frame_sync_out <= 1'b0;
		end else begin
			if (pop && rd_data[FIFO_FRAME_BIT]) begin
				frame_pend <= 1'b1;
			end else if (trail_cnt == FRAME_DELAY - 4'h1) begin
				frame_pend <= 1'b0;
			end
			if (trail_cnt == FRAME_DELAY - 4'h1) begin
				synthetic_frame_sync_out <= frame_pend;
			end
		end
	end

	sequence s_line_trail;
		$fell(aligned_line_sync_out) && frame_pend;
	endsequence
	sequence s_frame_rise;
		!synthetic_frame_sync_out [*1] ##7 synthetic_frame_sync_out;
	endsequence

	a_frame_delay: assert property (@(posedge pixel_clk_in) disable iff (px_rst)
		s_line_trail |-> ##1 s_frame_rise or (synthetic_frame_sync_out [*8]))
		else $error("frame sync not 8 clocks after line trailing edge");
	a_wide_toggle: assert property (@(posedge pixel_clk_in) disable iff (px_rst)
		in_wide && $past(in_wide) |-> half != $past(half))
		else $error("data clock not at half rate in wide mode");
	a_clock_inverse: assert property (@(posedge pixel_clk_in) disable iff (px_rst)
		!$past(px_rst) |-> pixel_data_clock_n_out == !pixel_data_clock_out)
		else $error("inverse data clock wrong");
	a_line_align: assert property (@(posedge pixel_clk_in) disable iff (px_rst)
		pop |=> aligned_line_sync_out == $past(rd_data[FIFO_LINE_BIT]))
		else $error("line sync not aligned with data");
	a_line_no_comp: assert property (@(posedge pixel_clk_in) disable iff (px_rst)
		composite && disrupt |-> !line_bit)
		else $error("composite content on aligned line sync");
	a_raw_passthru: assert property (@(posedge pixel_clk_in) disable iff (px_rst)
		!$past(px_rst) |-> raw_line_sync_buffered_out == $past(sel_sync))
		else $error("raw line sync not a copy of source");
	a_frame_hold: assert property (@(posedge pixel_clk_in) disable iff (px_rst)
		composite && disrupt |=> raw_frame_sync_buffered_out)
		else $error("frame sync dropped during disruption");
	a_bus_release: assert property (@(posedge pixel_clk_in) disable iff (px_rst)
		!in_bus_en |=> pixel_bus_oe_n_out ##0 !pop)
		else $error("buses not released when disabled");
	a_sec_alt: assert property (@(posedge pixel_clk_in) disable iff (px_rst)
		pop && in_wide && phase |=> {red_secondary_bus_out, green_secondary_bus_out,
		blue_secondary_bus_out} == $past(rd_data[FIFO_LINE_BIT-1:0]) && !phase)
		else $error("wide mode secondary pixel wrong");
	a_narrow_sec: assert property (@(posedge pixel_clk_in) disable iff (px_rst)
		pop && !in_wide |=> red_secondary_bus_out == '0 && blue_secondary_bus_out == '0
		&& !phase)
		else $error("secondary bus used in narrow mode");
endmodule : video_digitizer_output_port
`default_nettype wire

// File: bench/video_sink_model.sv
// downstream scaler model that logs pixel buses and sync timing
`timescale 1ns/1ps
`default_nettype none
module video_sink_model (
	input wire logic pixel_clk_in,
	input wire logic [23:0] primary_in,
	input wire logic [23:0] secondary_in,
	input wire logic bus_oe_n_in,
	input wire logic line_sync_in,
	input wire logic raw_line_in,
	input wire logic raw_frame_in
);
	logic [23:0] prim_q[$];
	logic [23:0] sec_q[$];
	logic [23:0] last_prim = 24'h000000;
	logic [23:0] last_sec = 24'h000000;
	logic [2:0] last_sync = 3'h0;
	int line_cnt = 0;
	int line_period = 0;
	int line_starts = 0;
	int frame_starts = 0;
	// logs each new bus word while the buses are driven
	always @(negedge pixel_clk_in) begin
		if (bus_oe_n_in === 1'b0 && primary_in !== last_prim) begin
			prim_q.push_back(primary_in);
		end
		if (bus_oe_n_in === 1'b0 && secondary_in !== last_sec) begin
			sec_q.push_back(secondary_in);
		end
		last_prim = primary_in;
		last_sec = secondary_in;
		line_cnt++;
		if (line_sync_in === 1'b1 && last_sync[0] === 1'b0) begin
			line_starts++;
		end
		if (raw_line_in === 1'b1 && last_sync[1] === 1'b0) begin
			line_period = line_cnt;
			line_cnt = 0;
		end
		if (raw_frame_in === 1'b1 && last_sync[2] === 1'b0) begin
			frame_starts++;
		end
		last_sync = {raw_frame_in, raw_line_in, line_sync_in};
	end
endmodule : video_sink_model
`default_nettype wire

// File: bench/video_digitizer_output_port_tb_top.sv
// self-checking bench for the video digitizer output port
`timescale 1ns/1ps
`default_nettype none
module video_digitizer_output_port_tb_top;
	import video_out_pkg::*;
	logic clk = 1'b0;
	logic pixel_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic reset_n = 1'b1;
	logic strap = 1'b0;
	logic m_scl = 1'b1;
	logic m_sda = 1'b1;
	logic half = 1'b0;
	logic [3:0] sync = 4'h0;
	logic [1:0] sel = 2'h0;
	logic wide = 1'b0;
	logic bus_en = 1'b0;
	logic inv = 1'b0;
	logic [23:0] pix = 24'h000000;
	logic valid = 1'b0;
	logic line_seen = 1'b0;
	wire sda_out, sda_oe_n, ready, oe_n, dclk, dclk_n, line_s, frame_s, raw_l, raw_f, xclk, sclk;
	wire [6:0] addr;
	wire [23:0] prim;
	wire [23:0] sec;
	wire sda_line;
	int error_cnt = 0;
	int checks = 0;
	int xcnt = 0;
	int dcnt = 0;
	assign sda_line = m_sda & (sda_oe_n | sda_out);
	always #25 clk = ~clk;
	initial begin
		#1.1;
		forever #3 pixel_clk = ~pixel_clk;
	end
	always @(posedge xclk) xcnt++;
	always @(posedge dclk) dcnt++;
	always @(negedge pixel_clk) if (line_s === 1'b1) line_seen = 1'b1;
	video_digitizer_output_port dut (.clk_in(clk), .sys_rst_in(sys_rst), .pixel_clk_in(pixel_clk),
		.reset_n_in(reset_n), .bus_addr_strap_in(strap), .scl_in(m_scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe_n_out(sda_oe_n), .slave_addr_out(addr),
		.crystal_half_in(half), .crystal_clock_buffered_out(xclk), .hsync_in(sync[0]),
		.sog_in(sync[1]), .csync_in(sync[2]), .vsync_in(sync[3]), .sync_select_in(sel),
		.mode_wide_in(wide), .bus_enable_in(bus_en), .sample_phase_invert_in(inv),
		.sample_clock_out(sclk), .adc_red_in(pix[23:16]), .adc_green_in(pix[15:8]),
		.adc_blue_in(pix[7:0]), .adc_valid_in(valid), .adc_ready_out(ready),
		.red_primary_bus_out(prim[23:16]), .green_primary_bus_out(prim[15:8]),
		.blue_primary_bus_out(prim[7:0]), .red_secondary_bus_out(sec[23:16]),
		.green_secondary_bus_out(sec[15:8]), .blue_secondary_bus_out(sec[7:0]),
		.pixel_bus_oe_n_out(oe_n), .pixel_data_clock_out(dclk), .pixel_data_clock_n_out(dclk_n),
		.aligned_line_sync_out(line_s), .synthetic_frame_sync_out(frame_s),
		.raw_line_sync_buffered_out(raw_l), .raw_frame_sync_buffered_out(raw_f));
	video_sink_model sink (.pixel_clk_in(pixel_clk), .primary_in(prim), .secondary_in(sec),
		.bus_oe_n_in(oe_n), .line_sync_in(line_s), .raw_line_in(raw_l), .raw_frame_in(raw_f));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic clks(input int n);
		repeat (n) @(negedge clk);
	endtask : clks
	task automatic pclks(input int n);
		repeat (n) @(negedge pixel_clk);
	endtask : pclks
	task automatic push_run(input logic [23:0] base, input int n, output int taken);
		int g;
		taken = 0;
		for (int i = 0; i < n; i++) begin
			@(negedge pixel_clk);
			pix = base + 24'(i);
			valid = 1'b1;
			g = 0;
			while (ready !== 1'b1 && g < 4) begin
				@(negedge pixel_clk);
				g++;
			end
			if (ready !== 1'b1) break;
			@(posedge pixel_clk);
			taken++;
		end
		@(negedge pixel_clk);
		valid = 1'b0;
	endtask : push_run
	task automatic i2c(input logic [6:0] a, output logic ack);
		logic [7:0] b;
		b = {a, 1'b0};
		m_sda = 1'b0;
		clks(10);
		m_scl = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			clks(5);
			m_sda = b[i];
			clks(5);
			m_scl = 1'b1;
			clks(10);
			m_scl = 1'b0;
		end
		clks(5);
		m_sda = 1'b1;
		clks(5);
		m_scl = 1'b1;
		clks(5);
		ack = ~sda_line;
		clks(5);
		m_scl = 1'b0;
		clks(5);
		m_sda = 1'b0;
		clks(5);
		m_scl = 1'b1;
		clks(10);
		m_sda = 1'b1;
		clks(20);
	endtask : i2c
	task automatic t_strap;
		logic ack;
		chk(sda_out, 0);
		i2c(7'h4C, ack);
		chk(ack, 1);
		i2c(7'h4D, ack);
		chk(ack, 0);
		strap = 1'b1;
		clks(8);
		chk(addr, 7'h4D);
		i2c(7'h4D, ack);
		chk(ack, 1);
		chk(sda_oe_n, 1);
		strap = 1'b0;
		clks(8);
		chk(addr, 7'h4C);
	endtask : t_strap
	task automatic t_xtal;
		clks(4);
		xcnt = 0;
		clks(20);
		chk(xcnt, 20);
		half = 1'b1;
		clks(4);
		xcnt = 0;
		clks(20);
		chk(xcnt, 10);
		half = 1'b0;
	endtask : t_xtal
	task automatic t_bus(input logic w, input logic [23:0] base, input int n);
		int tk;
		pclks(1);
		wide = w;
		bus_en = 1'b0;
		pclks(8);
		chk(oe_n, 1);
		sink.prim_q.delete();
		sink.sec_q.delete();
		push_run(base, n, tk);
		chk(tk, (n > 32) ? 32 : n);
		if (n > 32) chk(ready, 0);
		bus_en = 1'b1;
		pclks(50);
		chk(oe_n, 0);
		chk(sink.prim_q.size(), w ? tk / 2 : tk);
		chk(sink.sec_q.size(), w ? tk / 2 : 0);
		for (int i = 0; i < (w ? tk / 2 : tk); i++) begin
			chk(sink.prim_q[i], w ? base + 24'(2 * i) : base + 24'(i));
			if (w) chk(sink.sec_q[i], base + 24'(2 * i + 1));
		end
		dcnt = 0;
		pclks(20);
		chk(dcnt, w ? 10 : 20);
		#1;
		chk(dclk_n ^ dclk, 1);
	endtask : t_bus
	task automatic t_rawsync;
		for (int s = 0; s < 3; s++) begin
			sel = s[1:0];
			sync[2:0] = 3'h7 ^ (3'h1 << s);
			pclks(10);
			chk(raw_l, 0);
			sync[2:0] = 3'h1 << s;
			pclks(10);
			chk(raw_l, 1);
			sync[2:0] = 3'h0;
			pclks(10);
			chk(raw_l, 0);
		end
		chk(sink.line_period, 30);
	endtask : t_rawsync
	task automatic t_csync;
		int f0;
		int tk;
		sel = 2'h2;
		f0 = sink.frame_starts;
		sync[2] = 1'b1;
		pclks(76);
		chk(raw_f, 1);
		line_seen = 1'b0;
		push_run(24'h200000, 12, tk);
		pclks(10);
		chk(line_seen, 0);
		sync[2] = 1'b0;
		pclks(10);
		chk(raw_f, 1);
		sync[2] = 1'b1;
		pclks(8);
		sync[2] = 1'b0;
		pclks(10);
		chk(raw_f, 0);
		chk(sink.frame_starts, f0 + 1);
	endtask : t_csync
	task automatic t_frame;
		int tk;
		int g;
		int n;
		int l0;
		sel = 2'h0;
		l0 = sink.line_starts;
		sync[3] = 1'b1;
		pclks(8);
		fork
			push_run(24'h300000, 40, tk);
			begin
				pclks(5);
				sync[0] = 1'b1;
				pclks(10);
				sync[0] = 1'b0;
			end
			begin
				g = 0;
				while (line_s !== 1'b1 && g < 100) begin
					@(negedge pixel_clk);
					g++;
				end
				while (line_s !== 1'b0 && g < 100) begin
					@(negedge pixel_clk);
					g++;
				end
				chk(g < 100, 1);
				n = 0;
				while (frame_s !== 1'b1 && n < 20) begin
					@(negedge pixel_clk);
					n++;
				end
				chk(n, 8);
			end
		join
		chk(sink.line_starts, l0 + 1);
		sync[3] = 1'b0;
	endtask : t_frame
	task automatic t_misc;
		inv = 1'b1;
		pclks(8);
		#1;
		chk(sclk, 1);
		@(posedge pixel_clk);
		#1;
		chk(sclk, 0);
		@(negedge clk);
		reset_n = 1'b0;
		clks(20);
		chk(oe_n, 1);
		reset_n = 1'b1;
		clks(10);
		chk(oe_n, 0);
	endtask : t_misc
	task automatic end_sim;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		#400000;
		error_cnt++;
		end_sim();
	end
	initial begin
		clks(4);
		chk({oe_n, line_s, frame_s, sda_oe_n, addr}, {4'h9, 7'h4C});
		clks(1);
		sys_rst = 1'b0;
		clks(8);
		chk({oe_n, line_s, frame_s, sda_oe_n, addr}, {4'h9, 7'h4C});
		t_strap();
		t_xtal();
		t_bus(1'b0, 24'h102030, 3);
		t_bus(1'b0, 24'h0A0000, 40);
		t_bus(1'b1, 24'h405060, 4);
		t_rawsync();
		t_csync();
		t_frame();
		t_misc();
		end_sim();
	end
endmodule : video_digitizer_output_port_tb_top
`default_nettype wire
